// file: logic/dscx_execute.sv
/*
  Execute stage: one decoded operation in, result words and flags out.
  Assumes the fetch unit waits on ready and supplies register operands.
*/
`timescale 1ns/1ns
module dscx_execute
  import dscx_pkg::*;
(
  input wire logic clk_sys, // 250 MHz clock
  input wire logic nrst, // async reset, low
  input wire logic clkEn, // freezes state when low
  input wire dscx_instr_t instr, // decoded operation
  input wire logic [AW-1:0] accIn, // selected accumulator value
  output dscx_result_t result_ff, // result words and control
  output logic [AW-1:0] accOut_ff, // accumulator write value
  output logic accWrite_ff, // accumulator write strobe
  output dscx_flags_t flags_ff, // status flags
  output dscx_acc_flags_t accFlags_ff, // accumulator status
  output logic intHold_ff, // interrupts blocked
  output logic ready_ff // accepts next operation
);
  // ---------------------------------------------------------------
  // combinational datapath
  // ---------------------------------------------------------------
  logic [DW:0] sum;
  logic [4:0] halfSum;
  logic [DW:0] diff;
  logic [4:0] halfDiff;
  logic [DW-1:0] shiftOut;
  logic [4:0] pos;
  logic [31:0] prod;
  logic [AW-1:0] prodExt;
  logic [AW:0] accSum;
  logic condTrue;
  logic cmpTrue;
  logic [DW-1:0] bcd;
  logic bcdCarry;
  logic [DW-1:0] dsub;

  always_comb begin
    sum = {1'b0, instr.opA} + {1'b0, instr.opB}
        + {{DW{1'b0}}, flags_ff.carry};
    halfSum = {1'b0, instr.opA[3:0]} + {1'b0, instr.opB[3:0]}
            + {4'h0, flags_ff.carry};
    diff = {1'b0, instr.opA} - {1'b0, instr.opB}
         - {{DW{1'b0}}, ~flags_ff.carry};
    halfDiff = {1'b0, instr.opA[3:0]} - {1'b0, instr.opB[3:0]}
             - {4'h0, ~flags_ff.carry};
  end

  always_comb begin
    shiftOut = instr.opA;
    case (instr.op)
      OP_ARITH_RIGHT_SHIFT:
        shiftOut = DW'($signed(instr.opA) >>> (instr.useLit ?
          instr.lit[4:0] : {1'b0, instr.opB[3:0]}));
      OP_LSR_MULTI: shiftOut = instr.opA >> instr.opB[3:0];
      OP_LSR_ONE: shiftOut = {1'b0, instr.opA[DW-1:1]};
      default: shiftOut = instr.opA;
    endcase
  end

  // search positions: 1-based, zero when nothing found
  always_comb begin
    pos = NOT_FOUND;
    case (instr.op)
      OP_FIRST_ONE_FROM_LSB: begin
        for (int i = DW - 1; i >= 0; i--) begin
          if (instr.opB[i]) begin
            pos = 5'(i + 1);
          end
        end
      end
      OP_FIRST_ONE_FROM_MSB: begin
        for (int i = 0; i < DW; i++) begin
          if (instr.opB[i]) begin
            pos = 5'(DW - i);
          end
        end
      end
      OP_BIT_CHANGE_SEARCH: begin
        for (int i = 0; i < DW - 1; i++) begin
          if (instr.opB[i] != instr.opB[DW-1]) begin
            pos = 5'(DW - 1 - i);
          end
        end
      end
      default: pos = NOT_FOUND;
    endcase
  end

  always_comb begin
    logic [DW:0] sa;
    logic [DW:0] sb;
    sa = {instr.aSigned & instr.opA[DW-1], instr.opA};
    sb = {instr.bSigned & instr.opB[DW-1], instr.opB};
    prod = 32'($signed(sa) * $signed(sb));
    dsub = instr.opA - instr.opB;
    prodExt = AW'($signed(instr.op == OP_SQUARED_DISTANCE ?
      $signed(dsub) * $signed(dsub) : $signed(prod)));
  end

  always_comb begin
    accSum = {accIn[AW-1], accIn};
    case (instr.op)
      OP_SQUARED_DISTANCE:
        accSum = instr.accumulate ? {accIn[AW-1], accIn} +
          {prodExt[AW-1], prodExt} : {prodExt[AW-1], prodExt};
      OP_NEGATED_MULTIPLY:
        accSum = {1'b0, AW'(-prodExt)};
      OP_MULTIPLY_SUBTRACT_ACC:
        accSum = {accIn[AW-1], accIn} - {prodExt[AW-1], prodExt};
      default: accSum = {accIn[AW-1], accIn};
    endcase
  end

  always_comb begin
    logic sLess;
    sLess = flags_ff.negative ^ flags_ff.signedWrap;
    case (instr.cond)
      CC_C: condTrue = flags_ff.carry;
      CC_GE: condTrue = ~sLess;
      CC_GEU: condTrue = flags_ff.carry;
      CC_GT: condTrue = ~sLess & ~flags_ff.zero;
      CC_GTU: condTrue = flags_ff.carry & ~flags_ff.zero;
      CC_LE: condTrue = sLess | flags_ff.zero;
      CC_LEU: condTrue = ~flags_ff.carry | flags_ff.zero;
      CC_LT: condTrue = sLess;
      CC_LTU: condTrue = ~flags_ff.carry;
      CC_N: condTrue = flags_ff.negative;
      CC_NC: condTrue = ~flags_ff.carry;
      CC_NN: condTrue = ~flags_ff.negative;
      CC_NOV: condTrue = ~flags_ff.signedWrap;
      CC_NZ: condTrue = ~flags_ff.zero;
      CC_OV: condTrue = flags_ff.signedWrap;
      default: condTrue = flags_ff.zero;
    endcase
    case (instr.accCond)
      SEL_ACC_A_OV: condTrue = accFlags_ff.accAOverflow;
      SEL_ACC_B_OV: condTrue = accFlags_ff.accBOverflow;
      SEL_ACC_A_CLIP: condTrue = accFlags_ff.accAClipped;
      SEL_ACC_B_CLIP: condTrue = accFlags_ff.accBClipped;
      default: condTrue = condTrue;
    endcase
    case (instr.cmpMode)
      CMP_EQ: cmpTrue = instr.opA == instr.opB;
      CMP_GT: cmpTrue = $signed(instr.opA) > $signed(instr.opB);
      CMP_LT: cmpTrue = $signed(instr.opA) < $signed(instr.opB);
      default: cmpTrue = instr.opA != instr.opB;
    endcase
  end

  always_comb begin
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, instr.opA[3:0]};
    if (flags_ff.halfCarry || instr.opA[3:0] > BCD_LIMIT) begin
      lo = lo + {1'b0, BCD_FIX};
    end
    hi = {1'b0, instr.opA[7:4]} + {4'h0, lo[4]};
    if (flags_ff.carry || hi > {1'b0, BCD_LIMIT}) begin
      hi = hi + {1'b0, BCD_FIX};
    end
    bcd = {instr.opA[DW-1:8], hi[3:0], lo[3:0]};
    bcdCarry = hi[4] | flags_ff.carry;
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_DIV} dscx_state_t;
  dscx_state_t state_ff;
  logic [4:0] waitCnt_ff;
  logic [13:0] holdCnt_ff;
  logic [DW-1:0] divQ_ff;
  logic [DW-1:0] divR_ff;
  logic divErr_ff;
  logic take;
  logic isSecondWord;

  assign take = clkEn & ready_ff & instr.valid;
  assign isSecondWord = instr.word[23:16] == SECOND_WORD_TAG;

  // extra cycles of any operation only count down
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_RUN;
      waitCnt_ff <= 5'h00;
      ready_ff <= 1'b1;
    end else if (clkEn) begin
      case (state_ff)
        ST_RUN: begin
          if (take && !isSecondWord) begin
            waitCnt_ff <= 5'h00;
            case (instr.op)
              OP_JUMP_OP: waitCnt_ff <= condTrue ? 5'h01 : 5'h00;
              OP_BIT_TEST_SKIP_CLEAR:
                waitCnt_ff <= instr.opB[instr.bitSel] ? 5'h00 :
                  (instr.nextTwoWord ? 5'h02 : 5'h01);
              OP_COMPARE_SKIP:
                waitCnt_ff <= !cmpTrue ? 5'h00 :
                  (instr.nextTwoWord ? 5'h02 : 5'h01);
              OP_LOOP, OP_DOUBLE_MOVE, OP_DOUBLE_PULL:
                waitCnt_ff <= 5'h01;
              OP_DIVIDE: waitCnt_ff <= DIV_CYCLES - 5'h01;
              default: waitCnt_ff <= 5'h00;
            endcase
            if (instr.op == OP_DIVIDE) begin
              state_ff <= ST_DIV;
              ready_ff <= 1'b0;
            end else if ((instr.op == OP_JUMP_OP && condTrue) ||
                         instr.op inside {OP_LOOP, OP_DOUBLE_MOVE,
                         OP_DOUBLE_PULL, OP_BIT_TEST_SKIP_CLEAR,
                         OP_COMPARE_SKIP}) begin
              if ((instr.op != OP_BIT_TEST_SKIP_CLEAR ||
                   !instr.opB[instr.bitSel]) &&
                  (instr.op != OP_COMPARE_SKIP || cmpTrue)) begin
                state_ff <= ST_WAIT;
                ready_ff <= 1'b0;
              end
            end
          end
        end
        ST_WAIT, ST_DIV: begin
          waitCnt_ff <= waitCnt_ff - 5'h01;
          if (waitCnt_ff == 5'h01) begin
            state_ff <= ST_RUN;
            ready_ff <= 1'b1;
          end
        end
        default: state_ff <= ST_RUN;
      endcase
    end
  end

  // divide computed at issue, released after the full count
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      divQ_ff <= {DW{1'b0}};
      divR_ff <= {DW{1'b0}};
      divErr_ff <= 1'b0;
    end else if (clkEn && take && instr.op == OP_DIVIDE) begin
      divErr_ff <= instr.opB == {DW{1'b0}};
      if (instr.opB == {DW{1'b0}}) begin
        divQ_ff <= {DW{1'b1}};
        divR_ff <= instr.opA;
      end else if (instr.divFrac) begin
        divQ_ff <= DW'(($signed({instr.opA, {DW{1'b0}}}) >>> 1) /
                       $signed({{DW{instr.opB[DW-1]}}, instr.opB}));
        divR_ff <= {DW{1'b0}};
      end else if (instr.divSigned) begin
        divQ_ff <= DW'($signed(instr.opA) / $signed(instr.opB));
        divR_ff <= DW'($signed(instr.opA) % $signed(instr.opB));
      end else begin
        divQ_ff <= instr.opA / instr.opB;
        divR_ff <= instr.opA % instr.opB;
      end
    end
  end

  // interrupt hold counter
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      holdCnt_ff <= 14'h0000;
      intHold_ff <= 1'b0;
    end else if (clkEn) begin
      if (take && !isSecondWord && instr.op == OP_INTERRUPT_HOLD_CYCLES) begin
        holdCnt_ff <= instr.lit;
        intHold_ff <= instr.lit != 14'h0000;
      end else if (holdCnt_ff != 14'h0000) begin
        holdCnt_ff <= holdCnt_ff - 14'h0001;
        intHold_ff <= holdCnt_ff != 14'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // results and flags
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      result_ff <= '0;
      accOut_ff <= {AW{1'b0}};
      accWrite_ff <= 1'b0;
      flags_ff <= '0;
      accFlags_ff <= '0;
    end else if (clkEn) begin
      result_ff <= '0;
      accWrite_ff <= 1'b0;
      if (state_ff == ST_DIV && waitCnt_ff == 5'h01) begin
        result_ff.valid <= 1'b1;
        result_ff.lo <= divQ_ff;
        result_ff.hi <= divR_ff;
        result_ff.hiValid <= 1'b1;
        flags_ff.negative <= divQ_ff[DW-1];
        flags_ff.zero <= divR_ff == {DW{1'b0}};
        flags_ff.carry <= divR_ff == {DW{1'b0}};
        flags_ff.signedWrap <= divErr_ff;
      end else if (take && !isSecondWord) begin
        case (instr.op)
          OP_ADD_WITH_CARRY: begin
            result_ff.valid <= 1'b1;
            result_ff.lo <= sum[DW-1:0];
            flags_ff.carry <= sum[DW];
            flags_ff.halfCarry <= halfSum[4];
            flags_ff.negative <= sum[DW-1];
            flags_ff.signedWrap <= (instr.opA[DW-1] == instr.opB[DW-1]) &&
              (sum[DW-1] != instr.opA[DW-1]);
            flags_ff.zero <= sum[DW-1:0] == {DW{1'b0}};
          end
          OP_ARITH_RIGHT_SHIFT, OP_LSR_MULTI, OP_LSR_ONE: begin
            result_ff.valid <= 1'b1;
            result_ff.lo <= shiftOut;
            flags_ff.negative <= shiftOut[DW-1];
            flags_ff.zero <= shiftOut == {DW{1'b0}};
            if (instr.op == OP_LSR_ONE) begin
              flags_ff.carry <= instr.opA[0];
              flags_ff.signedWrap <= 1'b0;
            end
          end
          OP_JUMP_OP: result_ff.pcJump <= condTrue;
          OP_BIT_TEST_SKIP_CLEAR:
            result_ff.skip <= ~instr.opB[instr.bitSel];
          OP_COMPARE_SKIP: result_ff.skip <= cmpTrue;
          OP_TEST_THEN_SET_BIT: begin
            if (instr.altVariant) begin
              flags_ff.zero <= ~instr.opB[instr.bitSel];
            end else begin
              flags_ff.carry <= instr.opB[instr.bitSel];
            end
            result_ff.valid <= 1'b1;
            result_ff.lo <= instr.opB | (DW'(1) << instr.bitSel);
          end
          OP_COMPARE_WITH_BORROW: begin
            flags_ff.carry <= ~diff[DW];
            flags_ff.halfCarry <= ~halfDiff[4];
            flags_ff.negative <= diff[DW-1];
            flags_ff.signedWrap <= (instr.opA[DW-1] != instr.opB[DW-1]) &&
              (diff[DW-1] != instr.opA[DW-1]);
            // sticky zero: this op never sets it, only clears it on a nonzero difference
            flags_ff.zero <= flags_ff.zero &
              (diff[DW-1:0] == {DW{1'b0}});
          end
          OP_LOOP: begin
            result_ff.loopStart <= 1'b1;
            result_ff.loopCount <= (instr.useLit ? instr.lit :
              instr.opA[13:0]) + 14'h0001;
          end
          OP_BIT_CHANGE_SEARCH, OP_FIRST_ONE_FROM_LSB,
          OP_FIRST_ONE_FROM_MSB: begin
            result_ff.valid <= 1'b1;
            result_ff.lo <= {{(DW-5){1'b0}}, pos};
            flags_ff.carry <= pos == NOT_FOUND;
          end
          OP_DECIMAL_ADJUST: begin
            result_ff.valid <= 1'b1;
            result_ff.lo <= bcd;
            flags_ff.carry <= bcdCarry;
          end
          OP_PRODUCT_OP: begin
            result_ff.valid <= 1'b1;
            result_ff.hiValid <= 1'b1;
            result_ff.lo <= prod[DW-1:0];
            result_ff.hi <= prod[31:DW];
          end
          OP_DOUBLE_MOVE, OP_DOUBLE_PULL: begin
            result_ff.valid <= 1'b1;
            result_ff.hiValid <= 1'b1;
            result_ff.lo <= instr.opA;
            result_ff.hi <= instr.opB;
          end
          OP_SQUARED_DISTANCE, OP_NEGATED_MULTIPLY,
          OP_MULTIPLY_SUBTRACT_ACC: begin
            accWrite_ff <= 1'b1;
            accOut_ff <= accSum[AW-1:0];
            if (instr.op != OP_NEGATED_MULTIPLY) begin
              // overflow when the guard bits disagree; clipped stays set once set
              if (instr.accSel) begin
                accFlags_ff.accBOverflow <= accSum[AW] != accSum[AW-1];
                accFlags_ff.accBClipped <= accFlags_ff.accBClipped |
                  (accSum[AW] != accSum[AW-1]);
              end else begin
                accFlags_ff.accAOverflow <= accSum[AW] != accSum[AW-1];
                accFlags_ff.accAClipped <= accFlags_ff.accAClipped |
                  (accSum[AW] != accSum[AW-1]);
              end
            end
          end
          default: result_ff <= '0;
        endcase
      end
    end
  end
endmodule : dscx_execute

// file: logic/dscx_pkg.sv
/*
  Constants and carriers for the instruction execute block.
  Assumes a fetch unit that presents one decoded operation at a time.
*/
package dscx_pkg;
  localparam int unsigned DW = 16;
  localparam int unsigned AW = 40;
  localparam logic [4:0] DIV_CYCLES = 5'h12;
  localparam logic [7:0] SECOND_WORD_TAG = 8'h00;
  localparam logic [3:0] BCD_LIMIT = 4'h9;
  localparam logic [3:0] BCD_FIX = 4'h6;
  localparam logic [4:0] NOT_FOUND = 5'h00;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD_WITH_CARRY, OP_ARITH_RIGHT_SHIFT, OP_LSR_MULTI,
    OP_LSR_ONE, OP_JUMP_OP, OP_BIT_TEST_SKIP_CLEAR, OP_TEST_THEN_SET_BIT,
    OP_COMPARE_WITH_BORROW, OP_COMPARE_SKIP, OP_INTERRUPT_HOLD_CYCLES,
    OP_DIVIDE, OP_LOOP, OP_SQUARED_DISTANCE, OP_BIT_CHANGE_SEARCH,
    OP_FIRST_ONE_FROM_LSB, OP_FIRST_ONE_FROM_MSB, OP_DECIMAL_ADJUST,
    OP_PRODUCT_OP, OP_NEGATED_MULTIPLY, OP_MULTIPLY_SUBTRACT_ACC,
    OP_DOUBLE_MOVE, OP_DOUBLE_PULL
  } dscx_op_t;

  typedef enum logic [3:0] {
    CC_C, CC_GE, CC_GEU, CC_GT, CC_GTU, CC_LE, CC_LEU, CC_LT, CC_LTU,
    CC_N, CC_NC, CC_NN, CC_NOV, CC_NZ, CC_OV, CC_Z
  } dscx_cond_t;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_ACC_A_OV, SEL_ACC_B_OV, SEL_ACC_A_CLIP, SEL_ACC_B_CLIP
  } dscx_acc_cond_t;

  typedef enum logic [1:0] {
    CMP_EQ, CMP_GT, CMP_LT, CMP_NE
  } dscx_cmp_t;

  typedef struct packed {
    logic carry;
    logic halfCarry;
    logic negative;
    logic signedWrap;
    logic zero;
  } dscx_flags_t;

  typedef struct packed {
    logic accAOverflow;
    logic accBOverflow;
    logic accAClipped;
    logic accBClipped;
  } dscx_acc_flags_t;

  typedef struct packed {
    logic valid;
    logic [23:0] word;
    dscx_op_t op;
    logic [DW-1:0] opA;
    logic [DW-1:0] opB;
    logic [13:0] lit;
    logic [3:0] bitSel;
    logic useLit;
    logic altVariant;
    logic divSigned;
    logic divLong;
    logic divFrac;
    logic aSigned;
    logic bSigned;
    logic accSel;
    logic accumulate;
    logic nextTwoWord;
    dscx_cond_t cond;
    dscx_acc_cond_t accCond;
    dscx_cmp_t cmpMode;
  } dscx_instr_t;

  typedef struct packed {
    logic valid;
    logic [DW-1:0] lo;
    logic [DW-1:0] hi;
    logic hiValid;
    logic pcJump;
    logic skip;
    logic [13:0] loopCount;
    logic loopStart;
  } dscx_result_t;
endpackage : dscx_pkg

// file: testbench/dscx_execute_checker.sv
/*
  Timing and result checks on the execute block ports.
  Assumes one clock and the package carriers.
*/
`timescale 1ns/1ns
module dscx_execute_checker
  import dscx_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic nrst, // async reset, low
  input wire logic clkEn, // clock enable
  input wire dscx_instr_t instr, // operation
  input wire logic [AW-1:0] accIn, // accumulator in
  input wire dscx_result_t result_ff, // result
  input wire logic [AW-1:0] accOut_ff, // accumulator out
  input wire logic accWrite_ff, // accumulator strobe
  input wire dscx_flags_t flags_ff, // flags
  input wire dscx_acc_flags_t accFlags_ff, // accumulator flags
  input wire logic intHold_ff, // interrupts held
  input wire logic ready_ff // ready
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic take;
  logic [DW:0] addSum;
  logic signed [AW-1:0] negProd;
  assign take = clkEn && ready_ff && instr.valid &&
    instr.word[23:16] != SECOND_WORD_TAG;
  assign addSum = {1'b0, instr.opA} + {1'b0, instr.opB} + flags_ff.carry;
  assign negProd = -($signed(instr.opA) * $signed(instr.opB));
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence busy_one;
    !ready_ff ##1 ready_ff;
  endsequence
  sequence busy_two;
    !ready_ff [*2] ##1 ready_ff;
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  add_result_a: assert property (
    take && instr.op == OP_ADD_WITH_CARRY |=>
    result_ff.valid && result_ff.lo == $past(addSum[DW-1:0]) &&
    flags_ff.carry == $past(addSum[DW])) else $error("add result wrong");
  div_timing_a: assert property (
    take && instr.op == OP_DIVIDE |=>
    !ready_ff ##16 !ready_ff ##1 (ready_ff && result_ff.valid))
    else $error("divide timing wrong");
  jump_taken_a: assert property (
    take && instr.op == OP_JUMP_OP &&
    instr.accCond == SEL_NONE && instr.cond == CC_Z && flags_ff.zero |=>
    result_ff.pcJump ##0 busy_one) else $error("taken jump timing wrong");
  skip_two_a: assert property (
    take && instr.op == OP_BIT_TEST_SKIP_CLEAR &&
    !instr.opB[instr.bitSel] && instr.nextTwoWord |=> result_ff.skip ##0
    busy_two) else $error("two word skip timing wrong");
  cmp_flags_a: assert property (
    take && instr.op == OP_COMPARE_SKIP |=>
    $stable(flags_ff)) else $error("compare skip changed flags");
  product_pair_a: assert property (
    take && instr.op == OP_PRODUCT_OP |=>
    result_ff.hiValid && $stable(flags_ff)) else $error("product wrong");
  neg_product_a: assert property (
    take && instr.op == OP_NEGATED_MULTIPLY |=>
    accWrite_ff && accOut_ff == $past(negProd) && $stable(accFlags_ff))
    else $error("negated product wrong");
  lone_word_a: assert property (
    clkEn && ready_ff && instr.valid &&
    instr.word[23:16] == SECOND_WORD_TAG |=> !result_ff.valid && ready_ff &&
    $stable(flags_ff)) else $error("lone second word acted");
  hold_start_a: assert property (take &&
    instr.op == OP_INTERRUPT_HOLD_CYCLES && instr.lit != 14'h0000 |=>
    intHold_ff && $stable(flags_ff)) else $error("interrupt hold missing");
endmodule : dscx_execute_checker

bind dscx_execute dscx_execute_checker u_chk (.clk_sys(clk_sys),
  .nrst(nrst), .clkEn(clkEn), .instr(instr), .accIn(accIn),
  .result_ff(result_ff), .accOut_ff(accOut_ff), .accWrite_ff(accWrite_ff),
  .flags_ff(flags_ff), .accFlags_ff(accFlags_ff), .intHold_ff(intHold_ff),
  .ready_ff(ready_ff));

// file: testbench/dscx_acc_model.sv
/*
  Accumulator pair model beside the execute block.
  Assumes writes come as one-cycle strobes after the take.
*/
`timescale 1ns/1ns
module dscx_acc_model
  import dscx_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic nrst, // async reset, low
  input wire logic accSel, // 0 picks A, 1 picks B
  input wire logic accWrite, // write strobe
  input wire logic [AW-1:0] accOut, // write value
  output logic [AW-1:0] accIn // selected accumulator
);
  logic [AW-1:0] accA_ff;
  logic [AW-1:0] accB_ff;
  logic selQ_ff;
  // write lands in the one chosen when the op was taken
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      accA_ff <= '0;
      accB_ff <= '0;
      selQ_ff <= 1'b0;
    end else begin
      selQ_ff <= accSel;
      if (accWrite && !selQ_ff) accA_ff <= accOut;
      if (accWrite && selQ_ff) accB_ff <= accOut;
    end
  end
  assign accIn = accSel ? accB_ff : accA_ff;
endmodule : dscx_acc_model

// file: testbench/tb_top.sv
/*
  Self-checking bench for the execute block.
  Assumes inputs move on the falling edge.
*/
`timescale 1ns/1ns
module tb_top;
  import dscx_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  dscx_instr_t instr = '0;
  logic [AW-1:0] accIn;
  dscx_result_t result_ff;
  dscx_result_t got;
  logic [AW-1:0] accOut_ff;
  logic accWrite_ff;
  dscx_flags_t flags_ff;
  dscx_acc_flags_t accFlags_ff;
  logic intHold_ff;
  logic ready_ff;
  dscx_instr_t t;
  int n_mismatch = 0;
  int n_checks = 0;
  int nLow;
  always #2 clk_sys = ~clk_sys;
  dscx_execute dut (.clk_sys(clk_sys), .nrst(nrst), .clkEn(1'b1),
    .instr(instr), .accIn(accIn), .result_ff(result_ff),
    .accOut_ff(accOut_ff), .accWrite_ff(accWrite_ff), .flags_ff(flags_ff),
    .accFlags_ff(accFlags_ff), .intHold_ff(intHold_ff), .ready_ff(ready_ff));
  dscx_acc_model acc (.clk_sys(clk_sys), .nrst(nrst), .accSel(instr.accSel),
    .accWrite(accWrite_ff), .accOut(accOut_ff), .accIn(accIn));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  function automatic dscx_instr_t mk(input dscx_op_t op,
    input logic [15:0] a, input logic [15:0] b);
    dscx_instr_t i;
    i = '0;
    i.valid = 1'b1;
    i.word = 24'h5a0000;
    i.op = op;
    i.opA = a;
    i.opB = b;
    return i;
  endfunction : mk
  // called on a falling edge with ready high; counts busy cycles
  task automatic exec(input dscx_instr_t i);
    instr <= i;
    nLow = 0;
    @(negedge clk_sys);
    got = result_ff;
    if (ready_ff !== 1'b1) instr.valid <= 1'b0;
    while (ready_ff !== 1'b1 && nLow < 40) begin
      nLow++;
      @(negedge clk_sys);
      if (result_ff.valid === 1'b1) got = result_ff;
    end
    if (nLow == 40) begin
      n_mismatch++;
      close_out();
    end
  endtask : exec
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(negedge clk_sys);
    nrst <= 1'b1;
    @(negedge clk_sys);
    chk({ready_ff, flags_ff}, 6'h20);
    exec(mk(OP_ADD_WITH_CARRY, 16'hffff, 16'h0001));
    chk({got.lo, flags_ff}, {16'h0000, 5'b11001});
    exec(mk(OP_ADD_WITH_CARRY, 16'h7fff, 16'h0000));
    chk({got.lo, flags_ff}, {16'h8000, 5'b01110});
    t = mk(OP_ARITH_RIGHT_SHIFT, 16'h8000, 16'h0000);
    t.useLit = 1'b1;
    t.lit = 14'h0004;
    exec(t);
    chk({got.lo, flags_ff}, {16'hf800, 5'b01110});
    exec(mk(OP_LSR_MULTI, 16'h8000, 16'h0004));
    chk({got.lo, flags_ff}, {16'h0800, 5'b01010});
    exec(mk(OP_LSR_ONE, 16'h0001, 16'h0000));
    chk({got.lo, flags_ff.carry, flags_ff.negative, flags_ff.zero},
      {16'h0000, 3'b101});
    exec(mk(OP_COMPARE_WITH_BORROW, 16'h0005, 16'h0005));
    chk(flags_ff, 5'b11001);
    exec(mk(OP_DECIMAL_ADJUST, 16'h0000, 16'h0000));
    chk({got.lo, flags_ff}, {16'h0066, 5'b11001});
    t = mk(OP_JUMP_OP, 16'h0000, 16'h0000);
    t.cond = CC_Z;
    exec(t);
    chk({got.pcJump, 8'(nLow)}, 9'h101);
    t.cond = CC_NZ;
    exec(t);
    chk({got.pcJump, 8'(nLow)}, 9'h000);
    for (int k = 1; k <= 4; k++) begin
      t.accCond = dscx_acc_cond_t'(k);
      exec(t);
      chk({got.pcJump, 8'(nLow), flags_ff},
        {9'h000, 5'b11001});
    end
    for (int m = 0; m < 4; m++) begin
      t = mk(OP_COMPARE_SKIP, 16'h0005, 16'h0005);
      t.cmpMode = dscx_cmp_t'(m);
      t.nextTwoWord = 1'b1;
      exec(t);
      chk({got.skip, 8'(nLow), flags_ff},
        {(m == 0), (m == 0) ? 8'h02 : 8'h00, 5'b11001});
    end
    t = mk(OP_BIT_TEST_SKIP_CLEAR, 16'h0000, 16'hfff7);
    t.bitSel = 4'h3;
    exec(t);
    chk({got.skip, 8'(nLow)}, 9'h101);
    t.nextTwoWord = 1'b1;
    exec(t);
    chk({got.skip, 8'(nLow)}, 9'h102);
    t.opB = 16'h0008;
    exec(t);
    chk({got.skip, 8'(nLow)}, 9'h000);
    t = mk(OP_TEST_THEN_SET_BIT, 16'h0000, 16'h0020);
    t.bitSel = 4'h5;
    exec(t);
    chk({got.lo, flags_ff.carry}, {16'h0020, 1'b1});
    t.opB = 16'h0000;
    exec(t);
    chk({got.lo, flags_ff.carry}, {16'h0020, 1'b0});
    exec(mk(OP_DIVIDE, 16'h0100, 16'h0010));
    chk({got.lo, 8'(nLow), flags_ff.negative, flags_ff.signedWrap},
      {16'h0010, 8'h11, 2'b00});
    exec(mk(OP_FIRST_ONE_FROM_LSB, 16'h0000, 16'h0008));
    chk({got.lo, flags_ff.carry}, {16'h0004, 1'b0});
    exec(mk(OP_FIRST_ONE_FROM_LSB, 16'h0000, 16'h0000));
    chk({got.lo, flags_ff.carry}, {16'h0000, 1'b1});
    exec(mk(OP_FIRST_ONE_FROM_MSB, 16'h0000, 16'h0008));
    chk({got.lo, flags_ff.carry}, {16'h000d, 1'b0});
    exec(mk(OP_BIT_CHANGE_SEARCH, 16'h0000, 16'h0ff0));
    chk({got.lo, flags_ff.carry}, {16'h0004, 1'b0});
    exec(mk(OP_PRODUCT_OP, 16'hffff, 16'hffff));
    chk({got.hi, got.lo, got.hiValid}, {32'hfffe0001, 1'b1});
    t = mk(OP_PRODUCT_OP, 16'hffff, 16'hffff);
    t.aSigned = 1'b1;
    t.bSigned = 1'b1;
    exec(t);
    chk({got.hi, got.lo}, 32'h00000001);
    exec(mk(OP_NEGATED_MULTIPLY, 16'h0002, 16'h0003));
    chk({accWrite_ff, accOut_ff, accFlags_ff},
      {1'b1, 40'hfffffffffa, 4'h0});
    t = mk(OP_LOOP, 16'h0004, 16'h0000);
    t.lit = 14'h0005;
    exec(t);
    chk({got.loopStart, 8'(nLow), got.loopCount},
      {9'h101, 14'h0005});
    exec(mk(OP_DOUBLE_MOVE, 16'h1111, 16'h2222));
    chk({got.hiValid, 8'(nLow), got.hi, got.lo},
      {9'h101, 32'h22221111});
    exec(mk(OP_DOUBLE_PULL, 16'h3333, 16'h4444));
    chk({got.hiValid, 8'(nLow), got.hi, got.lo},
      {9'h101, 32'h44443333});
    exec(mk(OP_MULTIPLY_SUBTRACT_ACC, 16'h0002, 16'h0003));
    chk({accWrite_ff, accOut_ff, accFlags_ff},
      {1'b1, 40'hfffffffff4, 4'h0});
    t = mk(OP_SQUARED_DISTANCE, 16'h0005, 16'h0002);
    t.accSel = 1'b1;
    exec(t);
    chk({accWrite_ff, accOut_ff}, {1'b1, 40'h0000000009});
    t = mk(OP_INTERRUPT_HOLD_CYCLES, 16'h0000, 16'h0000);
    t.lit = 14'h0003;
    exec(t);
    chk(intHold_ff, 1'b1);
    t = mk(OP_ADD_WITH_CARRY, 16'h0001, 16'h0001);
    t.word = 24'h001234;
    exec(t);
    chk({got.valid, 8'(nLow)}, 9'h000);
    close_out();
  end
endmodule : tb_top
